// >>> scl_pkg.sv
// constants shared by the strap capture and link indicator block
package scl_pkg;
   // register byte offsets on the apb bus
   localparam logic [7:0] OFS_STRAP  = 8'h00;
   localparam logic [7:0] OFS_DELAY  = 8'h04;
   localparam logic [7:0] OFS_MGMT   = 8'h08;
   localparam logic [7:0] OFS_MODE   = 8'h0C;
   localparam logic [7:0] OFS_LINK   = 8'h10;
   // strap status fields
   localparam int STS_PD     = 0;
   localparam int STS_DELAY  = 1;
   localparam int STS_CODE0  = 4;
   localparam int STS_CODE1  = 6;
   localparam int STS_CODE2  = 8;
   localparam int STS_CODE3  = 10;
   localparam int STS_DONE   = 31;
   // delay control fields
   localparam int DLY_TX     = 0;
   localparam int DLY_RX     = 1;
   // management register fields
   localparam int MGT_ADDR   = 0;
   localparam int MGT_PAUSE  = 8;
   localparam int ADDR_W     = 5;
   localparam int MODE_W     = 4;
   // reset values
   localparam logic [ADDR_W-1:0] ADDR_RST  = 5'h00;
   localparam logic [MODE_W-1:0] MODE_RST  = 4'h0;
   localparam logic [1:0]        DELAY_RST = 2'h0;
   // connection codes of a configuration input
   localparam logic [1:0] CONN_GND  = 2'h0;
   localparam logic [1:0] CONN_FAST = 2'h1;
   localparam logic [1:0] CONN_GIG  = 2'h2;
   localparam logic [1:0] CONN_VDD  = 2'h3;
   // link speed encoding from the phy core
   localparam logic [1:0] SPD_TEN   = 2'h0;
   localparam logic [1:0] SPD_FAST  = 2'h1;
   localparam logic [1:0] SPD_GIG   = 2'h2;
   // timing
   localparam int CLK_MHZ       = 40;
   localparam int SETTLE_NS     = 1000;
   localparam int SETTLE_CYCLES = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   typedef enum logic [1:0] {
      stSample,
      stProbeA,
      stProbeB,
      stRun
   } scl_state_t;
endpackage : scl_pkg

// >>> scl_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module scl_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             sys_rst,
   // pins and synchronised copy
   input  wire logic [WIDTH-1:0] pinIn,
   output logic      [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_q  <= '0;
         syncOut <= '0;
      end else begin
         meta_q  <= pinIn;
         syncOut <= meta_q;
      end
   end
endmodule : scl_sync

// >>> scl_strap_decode.sv
// maps two probe samples of each configuration input to its connection code
`timescale 1ns/1ps
module scl_strap_decode #(
   parameter int NUM = 4
) (
   // samples taken with fast led high, then with gigabit led high
   input  wire logic [NUM-1:0]   sampleA,
   input  wire logic [NUM-1:0]   sampleB,
   // connection code per input
   output logic      [2*NUM-1:0] connCode
);
   genvar i;
   generate
      for (i = 0; i < NUM; i++) begin : g_dec
         // a follows fast, b follows gigabit, both high is supply
         assign connCode[2*i +: 2] = ( sampleA[i] &&  sampleB[i]) ? scl_pkg::CONN_VDD  :
                                     ( sampleA[i] && !sampleB[i]) ? scl_pkg::CONN_FAST :
                                     (!sampleA[i] &&  sampleB[i]) ? scl_pkg::CONN_GIG  :
                                                                     scl_pkg::CONN_GND;
      end
   endgenerate
endmodule : scl_strap_decode

// >>> scl_top.sv
// strap capture, configuration defaults and link leds with apb access
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - straps are captured once after reset; captured copies, not pins, set defaults
// - power-down strap high keeps the pll running during hardware power-down
// - power-down strap low stops the pll during hardware power-down
// - delay strap high makes tx and rx clock delay defaults enabled
// - delay strap low makes tx and rx clock delay defaults disabled
// - config input zero loads management address bits one and zero
// - config input one loads the pause bit and management address bit two
// - config input two loads operating select bits one and zero
// - config input three loads operating select bit three
// - ten led shows a link at 10 mb/s
// - fast led shows a link at 100 mb/s
// - gigabit led shows a link at 1000 mb/s
// - power-down input holds power-down mode; strap decides the pll
module scl_top #(
   parameter int                     SETTLE = scl_pkg::SETTLE_CYCLES,
   parameter logic                   LED_ON = 1'b1
) (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 sys_rst,
   // apb slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   // shared strap and led pins
   input  wire logic                 linkLedFastIn,
   output logic                      linkLedFastOut,
   output logic                      linkLedFastOe,
   input  wire logic                 linkLedGigabitIn,
   output logic                      linkLedGigabitOut,
   output logic                      linkLedGigabitOe,
   output logic                      linkLedTen,
   // configuration and power-down pins
   input  wire logic [3:0]           strapSelect,
   input  wire logic                 hardwarePowerdownInput,
   // phy core side
   input  wire logic                 linkUp,
   input  wire logic [1:0]           linkSpeed,
   output logic                      pllEnable,
   output logic                      powerdownActive,
   output logic                      txDelayEn,
   output logic                      rxDelayEn,
   output logic [scl_pkg::ADDR_W-1:0] managementAddressField,
   output logic                      pauseAdv,
   output logic [scl_pkg::MODE_W-1:0] operatingSelectField,
   output logic                      configDone
);
   localparam int TW = $clog2(SETTLE + 1);
   localparam logic [TW-1:0] SETTLE_T = TW'(SETTLE);

   scl_pkg::scl_state_t state_q, state_d;
   logic [TW-1:0] timer_q;
   logic          pdStrap_q, delayStrap_q;
   logic [3:0]    sampleA_q, sampleB_q;
   logic [7:0]    code_q;
   logic [1:0]    delay_q;
   logic [scl_pkg::ADDR_W-1:0] addr_q;
   logic          pause_q;
   logic [scl_pkg::MODE_W-1:0] mode_q;
   logic [31:0]   rdata_q;
   logic [6:0]    pinSync;
   logic [7:0]    connCode;

   // pins cross into the core clock before anything looks at them
   scl_sync #(.WIDTH(7)) u_sync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .pinIn   ({hardwarePowerdownInput, linkLedGigabitIn, linkLedFastIn, strapSelect}),
      .syncOut (pinSync)
   );

   wire [3:0] cfgSync   = pinSync[3:0];
   wire       fastSync  = pinSync[4];
   wire       gigSync   = pinSync[5];
   wire       hpdSync   = pinSync[6];

   scl_strap_decode #(.NUM(4)) u_dec (
      .sampleA  (sampleA_q),
      .sampleB  (sampleB_q),
      .connCode (connCode)
   );

   // sequencer: sample shared straps, probe config inputs twice, then run
   wire timerDone = (timer_q == SETTLE_T);
   wire inSample  = (state_q == scl_pkg::stSample);
   wire inProbeA  = (state_q == scl_pkg::stProbeA);
   wire inProbeB  = (state_q == scl_pkg::stProbeB);
   wire inRun     = (state_q == scl_pkg::stRun);
   // load in the first run cycle: the second probe sample lands only at the end of probe b
   wire loadNow   = inRun && !configDone;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         scl_pkg::stSample: if (timerDone) state_d = scl_pkg::stProbeA;
         scl_pkg::stProbeA: if (timerDone) state_d = scl_pkg::stProbeB;
         scl_pkg::stProbeB: if (timerDone) state_d = scl_pkg::stRun;
         scl_pkg::stRun:    state_d = scl_pkg::stRun;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q <= scl_pkg::stSample;
         timer_q <= '0;
      end else begin
         state_q <= state_d;
         timer_q <= (timerDone || inRun) ? '0 : timer_q + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pdStrap_q    <= 1'b0;
         delayStrap_q <= 1'b0;
         sampleA_q    <= 4'h0;
         sampleB_q    <= 4'h0;
         code_q       <= 8'h00;
      end else begin
         if (inSample && timerDone) begin
            pdStrap_q    <= fastSync;
            delayStrap_q <= gigSync;
         end
         if (inProbeA && timerDone) sampleA_q <= cfgSync;
         if (inProbeB && timerDone) sampleB_q <= cfgSync;
         if (inRun && !configDone) code_q <= connCode;
      end
   end

   // probe pattern: fast high first, gigabit high second
   wire ledFastOn = linkUp && (linkSpeed == scl_pkg::SPD_FAST);
   wire ledGigOn  = linkUp && (linkSpeed == scl_pkg::SPD_GIG);
   wire ledTenOn  = linkUp && (linkSpeed == scl_pkg::SPD_TEN);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         linkLedFastOut    <= 1'b0;
         linkLedFastOe     <= 1'b0;
         linkLedGigabitOut <= 1'b0;
         linkLedGigabitOe  <= 1'b0;
         linkLedTen        <= ~LED_ON;
         configDone        <= 1'b0;
      end else begin
         linkLedFastOe     <= !inSample;
         linkLedGigabitOe  <= !inSample;
         configDone        <= inRun;
         linkLedFastOut    <= inRun ? (ledFastOn ? LED_ON : ~LED_ON) : inProbeA;
         linkLedGigabitOut <= inRun ? (ledGigOn ? LED_ON : ~LED_ON) : inProbeB;
         linkLedTen        <= (inRun && ledTenOn) ? LED_ON : ~LED_ON;
      end
   end

   assign powerdownActive = hpdSync;
   assign pllEnable       = !(hpdSync && !pdStrap_q);

   // apb decode: zero wait states, data registered in the setup cycle
   wire setup    = psel && !penable;
   wire access   = psel && penable;
   wire hitStrap = (paddr == scl_pkg::OFS_STRAP);
   wire hitDelay = (paddr == scl_pkg::OFS_DELAY);
   wire hitMgmt  = (paddr == scl_pkg::OFS_MGMT);
   wire hitMode  = (paddr == scl_pkg::OFS_MODE);
   wire hitLink  = (paddr == scl_pkg::OFS_LINK);
   wire mapped   = hitStrap || hitDelay || hitMgmt || hitMode || hitLink;
   wire wrEn     = access && pwrite && mapped;

   // strap sampled from fast led pin has no write path; config input three sets only operating select bit three, which is writable
   wire [1:0] cfg0 = connCode[1:0];
   wire [1:0] cfg1 = connCode[3:2];
   wire [1:0] cfg2 = connCode[5:4];
   wire       cfg3 = (connCode[7:6] == scl_pkg::CONN_GIG);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         delay_q <= scl_pkg::DELAY_RST;
         addr_q  <= scl_pkg::ADDR_RST;
         pause_q <= 1'b0;
         mode_q  <= scl_pkg::MODE_RST;
      end else if (loadNow) begin
         delay_q   <= {2{delayStrap_q}};
         addr_q[1:0] <= cfg0;
         addr_q[2] <= cfg1[0];
         pause_q   <= cfg1[1];
         mode_q[1:0] <= cfg2;
         mode_q[3] <= cfg3;
      end else if (wrEn) begin
         if (hitDelay) delay_q <= pwdata[scl_pkg::DLY_RX:scl_pkg::DLY_TX];
         if (hitMgmt) addr_q <= pwdata[scl_pkg::MGT_ADDR +: scl_pkg::ADDR_W];
         if (hitMgmt) pause_q <= pwdata[scl_pkg::MGT_PAUSE];
         if (hitMode) mode_q <= pwdata[scl_pkg::MODE_W-1:0];
      end
   end

   assign txDelayEn              = delay_q[scl_pkg::DLY_TX];
   assign rxDelayEn              = delay_q[scl_pkg::DLY_RX];
   assign managementAddressField = addr_q;
   assign pauseAdv               = pause_q;
   assign operatingSelectField   = mode_q;

   wire [31:0] strapWord = {configDone, 19'h00000, code_q, 1'b0, 1'b0,
                            delayStrap_q, pdStrap_q};
   wire [31:0] rdMux = hitStrap ? strapWord :
                       hitDelay ? {30'h0, delay_q} :
                       hitMgmt  ? {23'h000000, pause_q, 3'h0, addr_q} :
                       hitMode  ? {28'h0000000, mode_q} :
                       hitLink  ? {29'h0, linkSpeed, linkUp} : 32'h00000000;

   always_ff @(posedge clk) begin
      if (sys_rst) rdata_q <= 32'h00000000;
      else if (setup && !pwrite) rdata_q <= rdMux;
   end

   assign prdata  = rdata_q;
   assign pready  = 1'b1;
   assign pslverr = access && !mapped;

   // no drive before the first probe
   property p_noEarlyDrive;
      @(posedge clk) disable iff (sys_rst)
         inSample |-> !linkLedFastOe && !linkLedGigabitOe;
   endproperty
   a_noEarlyDrive: assert property (p_noEarlyDrive) else $error("led driven while sampling");

   property p_pllKept;
      @(posedge clk) disable iff (sys_rst)
         (hpdSync && pdStrap_q) |-> pllEnable && powerdownActive;
   endproperty
   a_pllKept: assert property (p_pllKept) else $error("pll stopped with strap high");

   property p_pllStopped;
      @(posedge clk) disable iff (sys_rst)
         (hpdSync && !pdStrap_q) |-> !pllEnable;
   endproperty
   a_pllStopped: assert property (p_pllStopped) else $error("pll running with strap low");

   property p_delayDefault;
      @(posedge clk) disable iff (sys_rst)
         loadNow |=> (txDelayEn == delayStrap_q) && (rxDelayEn == delayStrap_q);
   endproperty
   a_delayDefault: assert property (p_delayDefault) else $error("delay default wrong");

   property p_addrLoad;
      @(posedge clk) disable iff (sys_rst)
         loadNow |=> managementAddressField[2:0] == {$past(cfg1[0]), $past(cfg0)};
   endproperty
   a_addrLoad: assert property (p_addrLoad) else $error("address bits not loaded");

   property p_pauseLoad;
      @(posedge clk) disable iff (sys_rst)
         loadNow |=> pauseAdv == $past(cfg1[1]);
   endproperty
   a_pauseLoad: assert property (p_pauseLoad) else $error("pause bit not loaded");

   property p_modeLoad;
      @(posedge clk) disable iff (sys_rst)
         loadNow |=> operatingSelectField == {$past(cfg3), 1'b0, $past(cfg2)};
   endproperty
   a_modeLoad: assert property (p_modeLoad) else $error("operating select not loaded");

   property p_ledGig;
      @(posedge clk) disable iff (sys_rst)
         (inRun && ledGigOn) |=> linkLedGigabitOut == LED_ON && linkLedFastOut == ~LED_ON;
   endproperty
   a_ledGig: assert property (p_ledGig) else $error("gigabit led wrong");

   property p_strapFrozen;
      @(posedge clk) disable iff (sys_rst)
         (configDone && $past(configDone)) |-> $stable(pdStrap_q) && $stable(code_q);
   endproperty
   a_strapFrozen: assert property (p_strapFrozen) else $error("captured strap changed");

   property p_delayOff;
      @(posedge clk) disable iff (sys_rst)
         (loadNow && !delayStrap_q) |=> !txDelayEn && !rxDelayEn;
   endproperty
   a_delayOff: assert property (p_delayOff) else $error("delay default not disabled");

   property p_ledTen;
      @(posedge clk) disable iff (sys_rst)
         (inRun && ledTenOn) |=> linkLedTen == LED_ON;
   endproperty
   a_ledTen: assert property (p_ledTen) else $error("ten led wrong");

   property p_ledFast;
      @(posedge clk) disable iff (sys_rst)
         (inRun && ledFastOn) |=> linkLedFastOut == LED_ON && linkLedGigabitOut == ~LED_ON;
   endproperty
   a_ledFast: assert property (p_ledFast) else $error("fast led wrong");
endmodule : scl_top

// >>> scl_board.sv
// board strap resistors and link leds around the shared pins
`timescale 1ns/1ps
module scl_board (
   // led drive from the device
   input  wire logic       fastOut,
   input  wire logic       fastOe,
   input  wire logic       gigOut,
   input  wire logic       gigOe,
   // resistor levels and connection code of each configuration input
   input  wire logic       pdPull,
   input  wire logic       dlyPull,
   input  wire logic [7:0] conn,
   // levels seen at the device pins
   output logic            fastIn,
   output logic            gigIn,
   output logic [3:0]      strapSel
);
   // a released pin falls to its strap resistor, never holds the last drive
   assign fastIn = fastOe ? fastOut : pdPull;
   assign gigIn  = gigOe ? gigOut : dlyPull;
   for (genvar i = 0; i < 4; i++) begin : g_sel
      assign strapSel[i] = (conn[2*i+:2] == scl_pkg::CONN_GND)  ? 1'b0   :
                           (conn[2*i+:2] == scl_pkg::CONN_FAST) ? fastIn :
                           (conn[2*i+:2] == scl_pkg::CONN_GIG)  ? gigIn  : 1'b1;
   end
endmodule : scl_board

// >>> strap_config_latch_tb.sv
// self-checking bench for strap capture, defaults and link leds
`timescale 1ns/1ps
module strap_config_latch_tb;
   localparam int SETTLE = 3;
   logic clk = 1'b0, sysRst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, conn = 8'h80, cur;
   logic [31:0] pwdata = 32'h0, rd, w, prdata;
   logic hardware_powerdown_input = 1'b0, linkUp = 1'b0, pdPull = 1'b0, dlyPull = 1'b0;
   logic [1:0] linkSpeed = 2'h0, spd;
   logic pdv, dlyv, lu, err, pready, pslverr, fIn, fOut, fOe, gIn, gOut, gOe, ten;
   logic pllEnable, pdAct, txDelayEn, rxDelayEn, pauseAdv, configDone;
   logic [3:0] strapSel, opSel;
   logic [4:0] mgmtAddr;
   int seed = 15, numErrors = 0, nCompared = 0, n;
   always #12.5 clk = ~clk;
   scl_top #(.SETTLE(SETTLE), .LED_ON(1'b1)) i_scl_top (.clk(clk), .sys_rst(sysRst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .linkLedFastIn(fIn),
      .linkLedFastOut(fOut), .linkLedFastOe(fOe), .linkLedGigabitIn(gIn),
      .linkLedGigabitOut(gOut), .linkLedGigabitOe(gOe), .linkLedTen(ten),
      .strapSelect(strapSel), .hardwarePowerdownInput(hardware_powerdown_input), .linkUp(linkUp),
      .linkSpeed(linkSpeed), .pllEnable(pllEnable), .powerdownActive(pdAct),
      .txDelayEn(txDelayEn), .rxDelayEn(rxDelayEn), .managementAddressField(mgmtAddr),
      .pauseAdv(pauseAdv), .operatingSelectField(opSel), .configDone(configDone));
   scl_board i_scl_board (.fastOut(fOut), .fastOe(fOe), .gigOut(gOut), .gigOe(gOe),
      .pdPull(pdPull), .dlyPull(dlyPull), .conn(conn), .fastIn(fIn), .gigIn(gIn),
      .strapSel(strapSel));
   function automatic logic [31:0] expMgmt();
      expMgmt = {23'h000000, cur[3], 5'h00, cur[2], cur[1:0]};
   endfunction : expMgmt
   function automatic logic [3:0] expMode();
      expMode = {cur[7:6] == scl_pkg::CONN_GIG, 1'b0, cur[5:4]};
   endfunction : expMode
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      nCompared++;
      if (seen !== exp) begin
         numErrors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      check(n < 50, 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic chkCfg();
      w = expMgmt();
      check(mgmtAddr, w[4:0]);
      check(pauseAdv, w[8]);
      check(opSel, expMode());
      check(txDelayEn, dlyv);
      check(rxDelayEn, dlyv);
      apb(1'b0, scl_pkg::OFS_MGMT, 32'h0);
      check(rd, w);
      apb(1'b0, scl_pkg::OFS_MODE, 32'h0);
      check(rd, {28'h0000000, expMode()});
      apb(1'b0, scl_pkg::OFS_DELAY, 32'h0);
      check(rd, {30'h00000000, dlyv, dlyv});
      apb(1'b0, scl_pkg::OFS_STRAP, 32'h0);
      check(rd, {1'b1, 19'h00000, cur, 2'h0, dlyv, pdv});
   endtask : chkCfg
   task automatic conclude();
      $display("compared %0d mismatches %0d", nCompared, numErrors);
      if (numErrors == 0 && nCompared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : conclude
   initial begin
      repeat (30000) @(posedge clk);
      numErrors++;
      conclude();
   end
   initial begin
      @(posedge clk);
      for (int t = 0; t < 10; t++) begin
         // corner cases walk every connection code through inputs zero to two
         if (t < 4) cur = {scl_pkg::CONN_GIG, 2'(t + 2), 2'(t + 1), 2'(t)};
         else cur = {scl_pkg::CONN_GIG, 6'($random(seed))};
         pdv = (t < 4) ? t[0] : 1'($random(seed));
         dlyv = (t < 4) ? t[1] : 1'($random(seed));
         // board keeps input three on the gigabit led
         conn <= cur;
         pdPull <= pdv;
         dlyPull <= dlyv;
         sysRst <= 1'b1;
         repeat (2) @(posedge clk);
         check(fOe | gOe, 1'b0);
         sysRst <= 1'b0;
         n = 0;
         while (configDone !== 1'b1 && n < 500) begin
            @(posedge clk);
            n++;
         end
         check(configDone, 1'b1);
         check({fOe, gOe}, 2'h3);
         chkCfg();
         // change every board strap except input three after capture: nothing may follow it
         conn <= {scl_pkg::CONN_GIG, ~cur[5:0]};
         pdPull <= ~pdv;
         dlyPull <= ~dlyv;
         repeat (10) @(posedge clk);
         chkCfg();
         hardware_powerdown_input <= 1'b1;
         repeat (4) @(posedge clk);
         check(pllEnable, pdv);
         check(pdAct, 1'b1);
         hardware_powerdown_input <= 1'b0;
         repeat (4) @(posedge clk);
         check(pllEnable, 1'b1);
         check(pdAct, 1'b0);
         spd = 2'(t % 3);
         lu = (t < 4) ? 1'b1 : 1'($random(seed));
         linkUp <= lu;
         linkSpeed <= spd;
         repeat (4) @(posedge clk);
         check(ten, lu && spd == scl_pkg::SPD_TEN);
         check(fOut, lu && spd == scl_pkg::SPD_FAST);
         check(gOut, lu && spd == scl_pkg::SPD_GIG);
         apb(1'b0, scl_pkg::OFS_LINK, 32'h0);
         check(rd, {29'h00000000, spd, lu});
         w = $random(seed);
         apb(1'b1, scl_pkg::OFS_MGMT, w);
         apb(1'b0, scl_pkg::OFS_MGMT, 32'h0);
         check(rd, w & 32'h0000011F);
         check(mgmtAddr, w[4:0]);
         apb(1'b1, scl_pkg::OFS_DELAY, w);
         check({txDelayEn, rxDelayEn}, {w[0], w[1]});
         apb(1'b1, scl_pkg::OFS_MODE, w);
         apb(1'b0, scl_pkg::OFS_MODE, 32'h0);
         check(rd, w & 32'h0000000F);
         check(opSel, w[3:0]);
         apb(1'b1, scl_pkg::OFS_STRAP, w);
         apb(1'b0, scl_pkg::OFS_STRAP, 32'h0);
         check(rd, {1'b1, 19'h00000, cur, 2'h0, dlyv, pdv});
         apb(1'b0, 8'h20, 32'h0);
         check(err, 1'b1);
         check(rd, 32'h00000000);
         $display("test %0d done", t);
      end
      conclude();
   end
endmodule : strap_config_latch_tb
